//--- include/vtl_pkg.sv
// package of constants and types for the vacuum threshold ui and led block
package vtl_pkg;

    // parameter indices reached over the parameter port
    localparam logic [15:0] VTL_IDX_SYS_CMD     = 16'h0002;
    localparam logic [15:0] VTL_IDX_COLOR_PROF  = 16'h0052;
    localparam logic [7:0]  VTL_CMD_LED_DEFAULT = 8'hAC;

    // colour entry field positions inside one 32-bit entry: r,g,b,brightness
    localparam int VTL_RED_POS    = 24;
    localparam int VTL_GREEN_POS  = 16;
    localparam int VTL_BLUE_POS   = 8;
    localparam int VTL_BRIGHT_POS = 0;
    // profile: upper entry = threshold reached, lower entry = ready
    localparam int VTL_REACHED_POS = 32;
    localparam int VTL_READY_POS   = 0;

    // factory colour entries
    localparam logic [31:0] VTL_RST_READY   = 32'h0000FFFF;
    localparam logic [31:0] VTL_RST_REACHED = 32'h0000FFFF;
    localparam logic [31:0] VTL_FLASH_BLUE   = 32'h0000FFFF;
    localparam logic [31:0] VTL_FLASH_ORANGE = 32'hFF8000FF;

    // pressure figures in mbar
    localparam logic [9:0] VTL_THR_RESET = 10'h1E0;
    localparam logic [9:0] VTL_THR_MIN   = 10'h064;
    localparam logic [9:0] VTL_THR_MAX   = 10'h258;
    localparam logic [9:0] VTL_THR_STEP  = 10'h00A;
    localparam logic [9:0] VTL_SEG_SPAN  = 10'h064;
    localparam int         VTL_BAR_LEDS  = 6;

    // timing
    localparam int VTL_CLK_HZ        = 10_000_000;
    localparam int VTL_SAVE_HOLD_MS  = 1000;
    localparam int VTL_IDLE_MS       = 5000;
    localparam int VTL_REPEAT_MS     = 200;
    localparam int VTL_FLASH_MS      = 1000;
    localparam int VTL_BLINK_MS      = 125;
    localparam int VTL_SAVE_HOLD_CYC = VTL_CLK_HZ / 1000 * VTL_SAVE_HOLD_MS;
    localparam int VTL_IDLE_CYC      = VTL_CLK_HZ / 1000 * VTL_IDLE_MS;
    localparam int VTL_REPEAT_CYC    = VTL_CLK_HZ / 1000 * VTL_REPEAT_MS;
    localparam int VTL_FLASH_CYC     = VTL_CLK_HZ / 1000 * VTL_FLASH_MS;
    localparam int VTL_BLINK_CYC     = VTL_CLK_HZ / 1000 * VTL_BLINK_MS;

    // parameter write port
    typedef struct packed {
        logic        wr;
        logic [15:0] index;
        logic [63:0] data;
    } vtl_param_wr_t;

    // ring drive
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } vtl_rgb_t;

    typedef enum logic [1:0] {
        VTL_IDLE   = 2'b00,
        VTL_ADJUST = 2'b01,
        VTL_FLASH  = 2'b11
    } vtl_mode_t;

endpackage

//--- src/vtl_bar.sv
// six-led threshold bar with proportional partial segment
`timescale 1ns/1ns
module vtl_bar
    import vtl_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       enable_i,
    input  wire logic [9:0] thr_i,
    output logic [7:0]      bar_level_o [VTL_BAR_LEDS]
);
    // per-led level: full when covered, fraction*255 when partly covered
    generate
        for (genvar i = 0; i < VTL_BAR_LEDS; i++)
        begin : g_seg
            localparam logic [9:0] LO = 10'(i) * VTL_SEG_SPAN;
            logic [9:0]  part;
            logic [17:0] scaled;
            logic [7:0]  lvl_nxt;
            always_comb
            begin
                part    = thr_i - LO;
                scaled  = 18'(part) * 18'h000FF;
                lvl_nxt = 8'h00;
                if (!enable_i || thr_i <= LO)
                    lvl_nxt = 8'h00;
                else if (thr_i >= LO + VTL_SEG_SPAN)
                    lvl_nxt = 8'hFF;                          // [RULE_07]
                else
                    lvl_nxt = 8'(scaled / 18'(VTL_SEG_SPAN)); // [RULE_06] [RULE_07]
            end
            always_ff @(posedge mclk_i)
            begin
                if (reset_i)
                    bar_level_o[i] <= 8'h00;
                else
                    bar_level_o[i] <= lvl_nxt;
            end
        end
    endgenerate
endmodule // vtl_bar

//--- src/vtl_ui.sv
// vacuum threshold buttons, status ring colour and part-present output
`timescale 1ns/1ns
// How it works
// RULE_01 - default ring shows part-present status steady blue
// RULE_02 - separate colour and brightness for ready and threshold reached
// RULE_03 - colour profile holds two four-byte entries r,g,b,brightness
// RULE_04 - brightness scales intensity only, hue stays the same
// RULE_05 - system command 0xAC restores led colour defaults
// RULE_06 - six-led bar shows threshold over 100 to 600 mbar (bar here spans 0 to 600 mbar, 100 mbar per led)
// RULE_07 - covered segments full, partial segment proportional brightness
// RULE_08 - tap steps threshold by 10 mbar, holding keeps stepping
// RULE_09 - first press only shows the bar, no adjustment
// RULE_10 - both buttons over one second saves and flashes blue
// RULE_11 - threshold above regulation setpoint rejected, flashes orange
// RULE_12 - five seconds idle: bar off, value discarded, flash orange
// RULE_13 - part-present output active when vacuum exceeds threshold
// RULE_14 - threshold resets to 480 mbar
// RULE_15 - button adjustments clamp threshold to 100..600 mbar
module vtl_ui
    import vtl_pkg::*;
#(
    parameter int SAVE_HOLD_CYC = VTL_SAVE_HOLD_CYC,
    parameter int IDLE_CYC      = VTL_IDLE_CYC,
    parameter int REPEAT_CYC    = VTL_REPEAT_CYC,
    parameter int FLASH_CYC     = VTL_FLASH_CYC,
    parameter int BLINK_CYC     = VTL_BLINK_CYC
)
(
    input  wire logic          mclk_i,
    input  wire logic          reset_i,
    input  wire vtl_param_wr_t param_i,
    input  wire logic [15:0]   param_rd_index_i,
    output logic [63:0]        param_rd_data_o,
    input  wire logic          btn_less_i,
    input  wire logic          btn_more_i,
    input  wire logic [9:0]    vacuum_i,
    input  wire logic [9:0]    regulation_setpoint_i,
    output vtl_rgb_t           ring_o,
    output logic [7:0]         bar_level_o [VTL_BAR_LEDS],
    output logic               part_present_output_o,
    output logic [9:0]         part_present_threshold_o
);
    // all state in one struct
    typedef struct packed {
        vtl_mode_t   mode;
        logic [9:0]  thr;
        logic [9:0]  edit;
        logic [31:0] ready_col;
        logic [31:0] reached_col;
        logic        flash_ok;
        logic [31:0] cnt;
        logic [31:0] idle;
        logic [31:0] both;
        logic [31:0] blink;
        logic        blink_on;
        logic        less_q;
        logic        more_q;
        logic        out;
        vtl_rgb_t    ring;
    } vtl_state_t;

    vtl_state_t st_r;
    vtl_state_t st_nxt;

    // scale one hue channel by brightness; ratios between channels survive
    function automatic logic [7:0] vtl_scale(input logic [7:0] c, input logic [7:0] b);
        logic [15:0] p;
        p = 16'(c) * 16'(b);
        return p[15:8] + {7'd0, p[7]};
    endfunction

    function automatic vtl_rgb_t vtl_drive(input logic [31:0] e);
        vtl_rgb_t r;
        r.red   = vtl_scale(e[VTL_RED_POS+:8], e[VTL_BRIGHT_POS+:8]);   // [RULE_04]
        r.green = vtl_scale(e[VTL_GREEN_POS+:8], e[VTL_BRIGHT_POS+:8]); // [RULE_04]
        r.blue  = vtl_scale(e[VTL_BLUE_POS+:8], e[VTL_BRIGHT_POS+:8]);  // [RULE_04]
        return r;
    endfunction

    // step with clamp to the displayable range
    function automatic logic [9:0] vtl_step(input logic [9:0] v, input logic up);
        if (up)
            return (v >= VTL_THR_MAX - VTL_THR_STEP) ? VTL_THR_MAX : v + VTL_THR_STEP;
        else
            return (v <= VTL_THR_MIN + VTL_THR_STEP) ? VTL_THR_MIN : v - VTL_THR_STEP;
    endfunction

    // one decode for a parameter write at a given index
    function automatic logic vtl_wr_hit(input vtl_param_wr_t w, input logic [15:0] idx);
        return w.wr && (w.index == idx);
    endfunction

    logic any_btn;
    logic both_btn;
    logic one_btn;
    logic new_press;
    logic up_dir;
    assign any_btn   = btn_less_i | btn_more_i;
    assign both_btn  = btn_less_i & btn_more_i;
    assign one_btn   = any_btn & ~both_btn;
    assign new_press = (btn_less_i & ~st_r.less_q) | (btn_more_i & ~st_r.more_q);
    assign up_dir    = btn_more_i;

    // next state
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.less_q = btn_less_i;
        st_nxt.more_q = btn_more_i;
        // parameter writes
        if (vtl_wr_hit(param_i, VTL_IDX_COLOR_PROF))
        begin
            st_nxt.reached_col = param_i.data[VTL_REACHED_POS+:32]; // [RULE_02] [RULE_03]
            st_nxt.ready_col   = param_i.data[VTL_READY_POS+:32];   // [RULE_03]
        end
        if (vtl_wr_hit(param_i, VTL_IDX_SYS_CMD)
            && param_i.data[7:0] == VTL_CMD_LED_DEFAULT)
        begin
            st_nxt.ready_col   = VTL_RST_READY;   // [RULE_05]
            st_nxt.reached_col = VTL_RST_REACHED; // [RULE_05]
        end
        // button sequence
        unique case (st_r.mode)
            VTL_IDLE:
            begin
                if (new_press)
                begin
                    st_nxt.mode = VTL_ADJUST;  // bar on, value unchanged [RULE_09]
                    st_nxt.edit = st_r.thr;
                    st_nxt.idle = 32'd0;
                    st_nxt.cnt  = 32'd0;
                    st_nxt.both = 32'd0;
                end
            end
            VTL_ADJUST:
            begin
                st_nxt.idle = any_btn ? 32'd0 : st_r.idle + 32'd1;
                st_nxt.both = both_btn ? st_r.both + 32'd1 : 32'd0;
                if (one_btn && new_press)
                begin
                    st_nxt.edit = vtl_step(st_r.edit, up_dir); // [RULE_08] [RULE_15]
                    st_nxt.cnt  = 32'd0;
                end
                else if (one_btn)
                begin
                    // auto-repeat while held [RULE_08]
                    if (st_r.cnt >= 32'(REPEAT_CYC - 1))
                    begin
                        st_nxt.edit = vtl_step(st_r.edit, up_dir); // [RULE_15]
                        st_nxt.cnt  = 32'd0;
                    end
                    else
                        st_nxt.cnt = st_r.cnt + 32'd1;
                end
                if (both_btn && st_r.both >= 32'(SAVE_HOLD_CYC))
                begin
                    st_nxt.mode = VTL_FLASH;
                    st_nxt.cnt  = 32'd0;
                    st_nxt.blink = 32'd0;
                    st_nxt.blink_on = 1'b1;
                    if (st_r.edit > regulation_setpoint_i)
                        st_nxt.flash_ok = 1'b0;               // [RULE_11]
                    else
                    begin
                        st_nxt.thr      = st_r.edit;          // [RULE_10]
                        st_nxt.flash_ok = 1'b1;               // [RULE_10]
                    end
                end
                else if (st_r.idle >= 32'(IDLE_CYC))
                begin
                    st_nxt.mode     = VTL_FLASH;              // discard edit [RULE_12]
                    st_nxt.flash_ok = 1'b0;                   // [RULE_12]
                    st_nxt.cnt      = 32'd0;
                    st_nxt.blink    = 32'd0;
                    st_nxt.blink_on = 1'b1;
                end
            end
            VTL_FLASH:
            begin
                st_nxt.cnt = st_r.cnt + 32'd1;
                if (st_r.blink >= 32'(BLINK_CYC - 1))
                begin
                    st_nxt.blink    = 32'd0;
                    st_nxt.blink_on = ~st_r.blink_on;
                end
                else
                    st_nxt.blink = st_r.blink + 32'd1;
                // buttons must be released first so a held save does not re-enter
                if (st_r.cnt >= 32'(FLASH_CYC - 1) && !any_btn)
                    st_nxt.mode = VTL_IDLE;
            end
            default:
                st_nxt.mode = VTL_IDLE;
        endcase
        // ring colour
        st_nxt.out = (vacuum_i > st_nxt.thr);  // [RULE_13]
        if (st_r.mode == VTL_FLASH)
            st_nxt.ring = st_r.blink_on
                ? vtl_drive(st_r.flash_ok ? VTL_FLASH_BLUE : VTL_FLASH_ORANGE) // [RULE_10] [RULE_11]
                : '0;
        else
            st_nxt.ring = vtl_drive(st_nxt.out ? st_r.reached_col : st_r.ready_col); // [RULE_01] [RULE_02]
    end

    // state register
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            st_r             <= '0;
            st_r.mode        <= VTL_IDLE;
            st_r.thr         <= VTL_THR_RESET;   // [RULE_14]
            st_r.edit        <= VTL_THR_RESET;
            st_r.ready_col   <= VTL_RST_READY;   // [RULE_01]
            st_r.reached_col <= VTL_RST_REACHED;
        end
        else
            st_r <= st_nxt;
    end

    // parameter readback
    always_comb
    begin
        param_rd_data_o = 64'h0000000000000000;
        if (param_rd_index_i == VTL_IDX_COLOR_PROF)
            param_rd_data_o = {st_r.reached_col, st_r.ready_col};
    end

    assign ring_o                   = st_r.ring;
    assign part_present_output_o    = st_r.out;
    assign part_present_threshold_o = st_r.thr;

    // bar shows the edited value only while adjusting
    vtl_bar u_bar (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .enable_i    (st_r.mode == VTL_ADJUST), // [RULE_06] [RULE_12]
        .thr_i       (st_r.edit),
        .bar_level_o (bar_level_o)
    );
endmodule // vtl_ui

//--- tb/vtl_link_model.sv
// partner model: parameter master and the two touch buttons
`timescale 1ns/1ns
module vtl_link_model
    import vtl_pkg::*;
(
    input  wire logic     mclk_i,
    output vtl_param_wr_t param_o = '0,
    output logic          less_o = 1'b0,
    output logic          more_o = 1'b0
);
    // one-cycle strobe; afterwards index and data go to the inverse so stale values never match
    task automatic put(input logic [15:0] idx, input logic [63:0] d);
        @(posedge mclk_i);
        param_o <= '{wr: 1'b1, index: idx, data: d};
        @(posedge mclk_i);
        param_o <= '{wr: 1'b0, index: ~idx, data: ~d};
    endtask
    // button levels held for n clocks, then both released
    task automatic hold(input logic l, input logic m, input int n);
        @(posedge mclk_i);
        less_o <= l;
        more_o <= m;
        repeat (n) @(posedge mclk_i);
        less_o <= 1'b0;
        more_o <= 1'b0;
    endtask
endmodule // vtl_link_model

//--- tb/vtl_ui_assertions.sv
// checker: port relations of the threshold ui block
`timescale 1ns/1ns
module vtl_ui_assertions
    import vtl_pkg::*;
(
    input wire logic          mclk_i,
    input wire logic          reset_i,
    input wire vtl_param_wr_t param_i,
    input wire logic [15:0]   param_rd_index_i,
    input wire logic [63:0]   param_rd_data_o,
    input wire logic          btn_less_i,
    input wire logic          btn_more_i,
    input wire logic [9:0]    vacuum_i,
    input wire logic [9:0]    regulation_setpoint_i,
    input wire vtl_rgb_t      ring_o,
    input wire logic [7:0]    bar_level_o [VTL_BAR_LEDS],
    input wire logic          part_present_output_o,
    input wire logic [9:0]    part_present_threshold_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // a single press while the bar is dark
    sequence idle_press_s;
        bar_level_o[0] == 8'h00 && !btn_less_i && $rose(btn_more_i);
    endsequence
    // first press lights the lowest bar segment two cycles later
    a_first_press: assert property (idle_press_s |-> ##2 bar_level_o[0] == 8'hFF)
        else $error("first press did not show the bar");
    // the output follows the threshold as it stands after a save, not the one before
    a_out_vacuum: assert property (
        1 |=> part_present_output_o == ($past(vacuum_i) > part_present_threshold_o))
        else $error("part present output wrong");
    a_thr_range: assert property (
        part_present_threshold_o >= 10'h064 && part_present_threshold_o <= 10'h258)
        else $error("threshold out of range");
    a_thr_reset: assert property ($past(reset_i) |-> part_present_threshold_o == 10'h1E0)
        else $error("threshold not restored by reset");
    a_bar_first: assert property (bar_level_o[0] == 8'h00 || bar_level_o[0] == 8'hFF)
        else $error("lowest segment partly lit");
    // the stored value only moves after both buttons were held
    a_save_both: assert property (
        $changed(part_present_threshold_o) |-> $past(btn_less_i && btn_more_i))
        else $error("threshold changed without a save");
    a_cmd_default: assert property (
        param_i.wr && param_i.index == VTL_IDX_SYS_CMD && param_i.data[7:0] == 8'hAC
        |=> param_rd_data_o == {VTL_RST_REACHED, VTL_RST_READY})
        else $error("led defaults not restored");
    a_prof_write: assert property (
        param_i.wr && param_i.index == VTL_IDX_COLOR_PROF |=> param_rd_data_o == $past(param_i.data))
        else $error("profile not stored");
endmodule // vtl_ui_assertions

bind vtl_ui vtl_ui_assertions vtl_ui_assertions_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .param_i(param_i),
    .param_rd_index_i(param_rd_index_i), .param_rd_data_o(param_rd_data_o),
    .btn_less_i(btn_less_i), .btn_more_i(btn_more_i), .vacuum_i(vacuum_i),
    .regulation_setpoint_i(regulation_setpoint_i), .ring_o(ring_o), .bar_level_o(bar_level_o),
    .part_present_output_o(part_present_output_o),
    .part_present_threshold_o(part_present_threshold_o));

//--- tb/vtl_ui_tb_top.sv
// testbench: ring colours, bar, buttons and threshold of the ui block
`timescale 1ns/1ns
module vtl_ui_tb_top;
    import vtl_pkg::*;
    logic          mclk_i = 1'b0;
    logic          reset_i = 1'b1;
    vtl_param_wr_t p;
    logic [15:0]   rd_idx = 16'h0052;
    logic [63:0]   rd;
    logic          less, more, pp;
    logic [9:0]    vac = 10'h000, reg_sp = 10'h258, thr;
    vtl_rgb_t      ring;
    logic [7:0]    bar [VTL_BAR_LEDS];
    int            bad_count = 0, compares = 0;

    vtl_link_model vtl_link_model_inst (.mclk_i(mclk_i), .param_o(p), .less_o(less), .more_o(more));
    // short counts keep the run small
    vtl_ui #(.SAVE_HOLD_CYC(20), .IDLE_CYC(50), .REPEAT_CYC(5), .FLASH_CYC(16), .BLINK_CYC(4))
    vtl_ui_inst (.mclk_i(mclk_i), .reset_i(reset_i), .param_i(p), .param_rd_index_i(rd_idx),
        .param_rd_data_o(rd), .btn_less_i(less), .btn_more_i(more), .vacuum_i(vac),
        .regulation_setpoint_i(reg_sp), .ring_o(ring), .bar_level_o(bar),
        .part_present_output_o(pp), .part_present_threshold_o(thr));

    initial forever #50 mclk_i = ~mclk_i;
    task chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1)
        begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // sample 1 ns after the edge so registered outputs have settled
    task cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // a blinking ring shows dark phases; orange at full brightness scales to fe,80,00
    task watch(input int n, output logic org, output logic dark);
        org = 1'b0;
        dark = 1'b0;
        repeat (n)
        begin
            cyc(1);
            if (ring === 24'hFE8000) org = 1'b1;
            if (ring === '0) dark = 1'b1;
        end
    endtask
    task t_reset();
        chk(thr === 10'h1E0 && pp === 1'b0, "reset threshold");
        chk(rd === {VTL_RST_REACHED, VTL_RST_READY}, "reset colours");
        chk(ring === 24'h0000FE, "steady blue");
    endtask
    // a reset in mid-run brings back the factory threshold and a steady ring
    task t_rerun();
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        cyc(2);
        chk(thr === 10'h1E0 && bar[0] === 8'h00, "threshold after reset");
        chk(ring === 24'h0000FE, "ring after reset");
    endtask
    task t_profile();
        vtl_link_model_inst.put(VTL_IDX_COLOR_PROF, 64'h00400080_40000080);
        cyc(3);
        chk(rd === 64'h00400080_40000080 && ring === 24'h200000, "ready colour");
        vtl_link_model_inst.put(VTL_IDX_COLOR_PROF, 64'h00400080_40000040);
        cyc(3);
        chk(ring === 24'h100000, "dimmed hue");
        @(posedge mclk_i);
        vac <= 10'h1F4;
        cyc(3);
        chk(pp === 1'b1 && ring === 24'h002000, "reached colour");
        vtl_link_model_inst.put(16'h0010, '1);
        cyc(1);
        chk(rd === 64'h00400080_40000040, "unmapped write ignored");
        @(posedge mclk_i);
        rd_idx <= 16'h0010;
        cyc(1);
        chk(rd === 64'h0, "unmapped read");
        @(posedge mclk_i);
        rd_idx <= VTL_IDX_COLOR_PROF;
        vac <= 10'h000;
        vtl_link_model_inst.put(VTL_IDX_SYS_CMD, 64'h00000000_000000AC);
        cyc(3);
        chk(rd === {VTL_RST_REACHED, VTL_RST_READY}, "factory colours");
    endtask
    task t_adjust();
        logic o, d;
        vtl_link_model_inst.hold(1'b0, 1'b1, 1);
        cyc(2);
        chk(bar[3] === 8'hFF && bar[4] === 8'hCC && bar[5] === 8'h00, "bar at 480");
        vtl_link_model_inst.hold(1'b0, 1'b1, 1);
        cyc(3);
        chk(bar[4] === 8'hE5 && thr === 10'h1E0, "tap step");
        vtl_link_model_inst.hold(1'b1, 1'b1, 25);
        watch(20, o, d);
        chk(d && !o && thr === 10'h1EA, "save");
        vtl_link_model_inst.hold(1'b0, 1'b1, 1);
        cyc(2);
        vtl_link_model_inst.hold(1'b0, 1'b1, 80);
        cyc(2);
        chk(bar[4] === 8'hFF && bar[5] === 8'hFF, "top segment");
        vtl_link_model_inst.hold(1'b1, 1'b1, 25);
        watch(20, o, d);
        chk(thr === 10'h258, "clamped save");
    endtask
    task t_reject();
        logic o, d;
        @(posedge mclk_i);
        reg_sp <= 10'h1E0;
        vtl_link_model_inst.hold(1'b0, 1'b1, 1);
        cyc(2);
        vtl_link_model_inst.hold(1'b1, 1'b0, 1);
        cyc(2);
        vtl_link_model_inst.hold(1'b1, 1'b1, 25);
        watch(20, o, d);
        chk(o && thr === 10'h258, "reject above setpoint");
        vtl_link_model_inst.hold(1'b0, 1'b1, 1);
        cyc(2);
        vtl_link_model_inst.hold(1'b1, 1'b0, 1);
        watch(75, o, d);
        chk(o && bar[0] === 8'h00 && thr === 10'h258, "idle timeout");
    endtask
    initial
    begin
        repeat (4) @(posedge mclk_i);
        reset_i <= 1'b0;
        cyc(3);
        t_reset();
        t_profile();
        t_adjust();
        t_reject();
        t_rerun();
        conclude();
    end
endmodule // vtl_ui_tb_top
